/* swap_caps_pkg.sv */
// Behaviour
// - entering sink swap request sends the role swap message and starts response timer
// - sink swap request returns to sink ready on reject, wait or timeout
// - sink swap request goes to sink power-off transition on accept
// - refusal state sends reject if swap impossible, wait if still evaluating
// - refusal state returns to sink ready once reject or wait is sent
// - source ready enters source cap query on manager request; sends query, starts timer
// - source cap query returns on caps, reject or timeout; reports outcome
// - source ready answers sink cap query with present caps, returns after sending
// - sink ready queries sink caps on request; returns on reply, reject, timeout; reports
// - sink ready or swap request answers source cap query, returns after sending
// - rail swap logic exists only when port can source the cable rail
// - rail swap request entered from ready on manager request; sends swap, starts timer
// - accept moves to wait-partner-rail if rail on, else rail turn-on
// - rail swap request returns to prior ready on reject, wait or timeout
// - wait-partner-rail starts rail-on timer; ready message to turn-off; expiry to hard reset
// - rail turn-off asks manager to switch rail off; returns to ready when off
// - rail turn-on asks manager to switch rail on; then sends ready message, returns
// - hard reset goes to source state for provider roles, sink state otherwise
package swap_caps_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned SENDER_RESP_US    = 27;   // response timer, plain default
  localparam int unsigned RAIL_ON_US        = 100;  // rail-on timer, plain default
  localparam int unsigned SENDER_RESP_CYC   = (SENDER_RESP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RAIL_ON_CYC       = (RAIL_ON_US * (CLK_HZ / 1_000_000));
  localparam int unsigned TMR_W             = 16;

  // ==========================================================
  // message codes handed to / from the protocol layer
  typedef enum logic [3:0] {
    MSG_NONE       = 4'h0,
    MSG_ACCEPT     = 4'h1,
    MSG_REJECT     = 4'h2,
    MSG_WAIT       = 4'h3,
    MSG_PS_RDY     = 4'h4,
    MSG_PR_SWAP    = 4'h5,
    MSG_RAIL_SWAP  = 4'h6,
    MSG_GET_SRC    = 4'h7,
    MSG_GET_SNK    = 4'h8,
    MSG_SRC_CAPS   = 4'h9,
    MSG_SNK_CAPS   = 4'ha
  } msg_t;

  // ==========================================================
  // policy states
  typedef enum logic [3:0] {
    source_ready_state              = 4'h0,
    sink_ready_state                = 4'h1,
    sink_role_swap_request_state    = 4'h2,
    sink_role_swap_refusal_state    = 4'h3,
    sink_power_off_transition_state = 4'h4,
    source_side_cap_query_state     = 4'h5,
    source_side_cap_reply_state     = 4'h6,
    sink_side_cap_query_state       = 4'h7,
    sink_side_cap_reply_state       = 4'h8,
    rail_swap_request_state         = 4'h9,
    wait_partner_rail_state         = 4'ha,
    rail_turn_on_state              = 4'hb,
    rail_turn_off_state             = 4'hc,
    rail_send_ready_state           = 4'hd,
    source_hard_reset_state         = 4'he,
    sink_hard_reset_state           = 4'hf
  } pe_state_t;

  // outcome codes reported to the manager
  localparam logic [1:0] OUT_CAPS    = 2'h1;
  localparam logic [1:0] OUT_REJECT  = 2'h2;
  localparam logic [1:0] OUT_TIMEOUT = 2'h3;

  localparam pe_state_t RESET_STATE = sink_ready_state;

endpackage

/* timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
// start/stop and expiry between the state machine and a timer
interface timer_if;
  logic start;
  logic stop;
  logic expired;
  modport ctl (output start, output stop, input expired);
  modport tmr (input start, input stop, output expired);
endinterface
`default_nettype wire

/* one_shot_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module one_shot_timer #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  timer_if.tmr      t
);
  import swap_caps_pkg::*;

  typedef struct packed {
    logic             run;
    logic [TMR_W-1:0] cnt;
    logic             exp;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  // ==========================================================
  // countdown; stop wins so a late expiry never leaks out
  always_comb begin
    s_d     = s_q;
    s_d.exp = 1'b0;
    if (t.stop) begin
      s_d.run = 1'b0;
    end else if (t.start) begin
      s_d.run = 1'b1;
      s_d.cnt = TMR_W'(CYCLES - 1);
    end else if (s_q.run) begin
      if (s_q.cnt == '0) begin
        s_d.run = 1'b0;
        s_d.exp = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.expired = s_q.exp;
endmodule
`default_nettype wire

/* swap_caps_fsm.sv */
`timescale 1ns/1ps
`default_nettype none
module swap_caps_fsm #(
  parameter bit RAIL_CAPABLE   = 1'b1,   // port can source the cable rail
  parameter bit PROVIDER_ROLE  = 1'b1    // default role provider or provider/consumer
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // protocol layer
  input  wire logic                      rx_valid,
  input  wire swap_caps_pkg::msg_t       rx_msg,
  output logic                           tx_req,
  output swap_caps_pkg::msg_t            tx_msg,
  input  wire logic                      tx_done,
  // local policy manager
  input  wire logic                      dpm_is_source,
  input  wire logic                      dpm_is_dfp,
  input  wire logic                      dpm_get_src_cap_req,
  input  wire logic                      dpm_get_snk_cap_req,
  input  wire logic                      dpm_pr_swap_req,
  input  wire logic                      dpm_rail_swap_req,
  input  wire logic                      dpm_refuse_pending,
  input  wire logic                      dpm_swap_wait,
  input  wire logic                      dpm_rail_is_on,
  output logic                           dpm_rail_on_cmd,
  output logic                           dpm_rail_off_cmd,
  output logic                           dpm_caps_fetch,
  output logic                           outcome_valid,
  output logic [1:0]                     outcome_code,
  output logic                           hard_reset_req,
  output swap_caps_pkg::pe_state_t       state
);
  import swap_caps_pkg::*;

  typedef struct packed {
    pe_state_t  st;
    logic       src_home;   // ready state to return to
    logic       sent;       // message of this state already requested
    logic       tx_req;
    msg_t       tx_msg;
    logic       rail_on;
    logic       rail_off;
    logic       fetch;
    logic       out_v;
    logic [1:0] out_c;
  } fsm_state_t;

  fsm_state_t s_q;
  fsm_state_t s_d;

  timer_if resp_t ();
  timer_if rail_t ();

  // ==========================================================
  // timers
  one_shot_timer #(.CYCLES(SENDER_RESP_CYC)) u_resp (
    .clk   (clk),
    .rst_n (rst_n),
    .t     (resp_t)
  );

  one_shot_timer #(.CYCLES(RAIL_ON_CYC)) u_rail (
    .clk   (clk),
    .rst_n (rst_n),
    .t     (rail_t)
  );

  logic rx_accept;
  logic rx_reject;
  logic rx_wait;
  logic rx_ps_rdy;
  logic rail_ok;

  // received message decode
  assign rx_accept = rx_valid && (rx_msg == MSG_ACCEPT);
  assign rx_reject = rx_valid && (rx_msg == MSG_REJECT);
  assign rx_wait   = rx_valid && (rx_msg == MSG_WAIT);
  assign rx_ps_rdy = rx_valid && (rx_msg == MSG_PS_RDY);
  assign rail_ok   = RAIL_CAPABLE && dpm_is_dfp;

  // ==========================================================
  // next state
  always_comb begin
    s_d          = s_q;
    s_d.tx_req   = 1'b0;
    s_d.out_v    = 1'b0;
    s_d.fetch    = 1'b0;
    resp_t.start = 1'b0;
    resp_t.stop  = 1'b0;
    rail_t.start = 1'b0;
    rail_t.stop  = 1'b0;
    case (s_q.st)
      source_ready_state: begin
        s_d.src_home = 1'b1;
        s_d.sent     = 1'b0;
        if (!dpm_is_source) begin
          s_d.st = sink_ready_state;
        end else if (rx_valid && rx_msg == MSG_GET_SNK) begin
          s_d.st    = source_side_cap_reply_state;
          s_d.fetch = 1'b1;
        end else if (dpm_get_src_cap_req) begin
          s_d.st = source_side_cap_query_state;
        end else if (dpm_rail_swap_req && rail_ok) begin
          s_d.st = rail_swap_request_state;
        end
      end
      sink_ready_state: begin
        s_d.src_home = 1'b0;
        s_d.sent     = 1'b0;
        if (dpm_is_source) begin
          s_d.st = source_ready_state;
        end else if (rx_valid && rx_msg == MSG_GET_SRC) begin
          s_d.st    = sink_side_cap_reply_state;
          s_d.fetch = 1'b1;
        end else if (rx_valid && rx_msg == MSG_PR_SWAP && dpm_refuse_pending) begin
          s_d.st = sink_role_swap_refusal_state;
        end else if (dpm_pr_swap_req) begin
          s_d.st = sink_role_swap_request_state;
        end else if (dpm_get_snk_cap_req) begin
          s_d.st = sink_side_cap_query_state;
        end else if (dpm_rail_swap_req && rail_ok) begin
          s_d.st = rail_swap_request_state;
        end
      end
      // request states: send once, start timer, wait for reply
      sink_role_swap_request_state: begin
        if (!s_q.sent) begin
          s_d.tx_req   = 1'b1;
          s_d.tx_msg   = MSG_PR_SWAP;
          s_d.sent     = 1'b1;
          resp_t.start = 1'b1;
        end else if (rx_accept) begin
          s_d.st      = sink_power_off_transition_state;
          resp_t.stop = 1'b1;
        end else if (rx_valid && rx_msg == MSG_GET_SRC) begin
          s_d.st      = sink_side_cap_reply_state;
          s_d.sent    = 1'b0;
          s_d.fetch   = 1'b1;
          resp_t.stop = 1'b1;
        end else if (rx_reject || rx_wait || resp_t.expired) begin
          s_d.st      = sink_ready_state;
          resp_t.stop = 1'b1;
        end
      end
      sink_role_swap_refusal_state: begin
        if (!s_q.sent) begin
          s_d.tx_req = 1'b1;
          s_d.tx_msg = dpm_swap_wait ? MSG_WAIT : MSG_REJECT;
          s_d.sent   = 1'b1;
        end else if (tx_done) begin
          s_d.st = sink_ready_state;
        end
      end
      sink_power_off_transition_state: begin
        // hand-off point to the rest of the swap sequence
        if (dpm_is_source) begin
          s_d.st = source_ready_state;
        end
      end
      source_side_cap_query_state, sink_side_cap_query_state: begin
        if (!s_q.sent) begin
          s_d.tx_req   = 1'b1;
          s_d.tx_msg   = (s_q.st == source_side_cap_query_state) ? MSG_GET_SRC : MSG_GET_SNK;
          s_d.sent     = 1'b1;
          resp_t.start = 1'b1;
        end else if ((rx_valid && (rx_msg == MSG_SRC_CAPS || rx_msg == MSG_SNK_CAPS))
                     || rx_reject || resp_t.expired) begin
          s_d.st      = s_q.src_home ? source_ready_state : sink_ready_state;
          s_d.out_v   = 1'b1;
          s_d.out_c   = rx_reject ? OUT_REJECT : (resp_t.expired ? OUT_TIMEOUT : OUT_CAPS);
          resp_t.stop = 1'b1;
        end
      end
      source_side_cap_reply_state, sink_side_cap_reply_state: begin
        if (!s_q.sent) begin
          s_d.tx_req = 1'b1;
          s_d.tx_msg = (s_q.st == source_side_cap_reply_state) ? MSG_SNK_CAPS : MSG_SRC_CAPS;
          s_d.sent   = 1'b1;
        end else if (tx_done) begin
          s_d.st = (s_q.st == source_side_cap_reply_state) ? source_ready_state
                                                            : sink_ready_state;
        end
      end
      rail_swap_request_state: begin
        if (!s_q.sent) begin
          s_d.tx_req   = 1'b1;
          s_d.tx_msg   = MSG_RAIL_SWAP;
          s_d.sent     = 1'b1;
          resp_t.start = 1'b1;
        end else if (rx_accept) begin
          s_d.st      = dpm_rail_is_on ? wait_partner_rail_state : rail_turn_on_state;
          s_d.sent    = 1'b0;
          resp_t.stop = 1'b1;
        end else if (rx_reject || rx_wait || resp_t.expired) begin
          s_d.st      = s_q.src_home ? source_ready_state : sink_ready_state;
          resp_t.stop = 1'b1;
        end
      end
      wait_partner_rail_state: begin
        // an early ready message must not be lost while the timer is being armed
        if (rx_ps_rdy) begin
          s_d.st      = rail_turn_off_state;
          rail_t.stop = 1'b1;
        end else if (!s_q.sent) begin
          rail_t.start = 1'b1;
          s_d.sent     = 1'b1;
        end else if (rail_t.expired) begin
          s_d.st = PROVIDER_ROLE ? source_hard_reset_state : sink_hard_reset_state;
        end
      end
      rail_turn_off_state: begin
        s_d.rail_off = 1'b1;
        // command stands at least one cycle even if the rail is already off
        if (s_q.rail_off && !dpm_rail_is_on) begin
          s_d.rail_off = 1'b0;
          s_d.st       = s_q.src_home ? source_ready_state : sink_ready_state;
        end
      end
      rail_turn_on_state: begin
        s_d.rail_on = 1'b1;
        if (s_q.rail_on && dpm_rail_is_on) begin
          s_d.rail_on = 1'b0;
          s_d.st      = rail_send_ready_state;
          s_d.sent    = 1'b0;
        end
      end
      rail_send_ready_state: begin
        if (!s_q.sent) begin
          s_d.tx_req = 1'b1;
          s_d.tx_msg = MSG_PS_RDY;
          s_d.sent   = 1'b1;
        end else if (tx_done) begin
          s_d.st = s_q.src_home ? source_ready_state : sink_ready_state;
        end
      end
      source_hard_reset_state, sink_hard_reset_state: begin
        // hard reset handled outside; resume in the default role
        s_d.st = (s_q.st == source_hard_reset_state) ? source_ready_state : sink_ready_state;
      end
      default: begin
        s_d.st = RESET_STATE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.st       <= RESET_STATE;
      s_q.tx_msg   <= MSG_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops, except hard_reset_req, which is decoded from the state register
  assign tx_req           = s_q.tx_req;
  assign tx_msg           = s_q.tx_msg;
  assign dpm_rail_on_cmd  = s_q.rail_on;
  assign dpm_rail_off_cmd = s_q.rail_off;
  assign dpm_caps_fetch   = s_q.fetch;
  assign outcome_valid    = s_q.out_v;
  assign outcome_code     = s_q.out_c;
  assign hard_reset_req   = (s_q.st == source_hard_reset_state) || (s_q.st == sink_hard_reset_state);
  assign state            = s_q.st;
endmodule
`default_nettype wire

/* far_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
module far_end_model
  import swap_caps_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                tx_req,
  input  wire swap_caps_pkg::msg_t reply,
  input  wire logic [7:0]          gap,
  input  wire logic                inj,
  input  wire swap_caps_pkg::msg_t inj_msg,
  output swap_caps_pkg::msg_t      rx_msg,
  output logic                     rx_valid,
  output logic                     tx_done
);
  logic [7:0] t_q;
  // ==========================================================
  // partner behind the protocol layer
  // ack each send after one cycle, answer after gap; idle bus toggles so stale data never looks valid
  always_ff @(posedge clk) begin
    tx_done  <= 1'b0;
    rx_valid <= 1'b0;
    rx_msg   <= msg_t'(~rx_msg);
    if (!rst_n) begin
      t_q    <= 8'h00;
      rx_msg <= MSG_NONE;
    end else if (inj) begin
      rx_valid <= 1'b1;
      rx_msg   <= inj_msg;
    end else if (tx_req) begin
      t_q <= 8'h01;
    end else if (t_q != 8'h00) begin
      t_q     <= t_q + 8'h01;
      tx_done <= (t_q == 8'h01);
      if (t_q == gap) begin
        t_q      <= 8'h00;
        rx_valid <= (reply != MSG_NONE);
        rx_msg   <= reply;
      end
    end
  end
endmodule
`default_nettype wire

/* swap_caps_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module swap_caps_chk
  import swap_caps_pkg::*;
#(
  parameter bit PROVIDER_ROLE = 1'b1
) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      rx_valid,
  input wire swap_caps_pkg::msg_t       rx_msg,
  input wire logic                      tx_req,
  input wire swap_caps_pkg::msg_t       tx_msg,
  input wire logic                      tx_done,
  input wire logic                      dpm_is_dfp,
  input wire logic                      dpm_swap_wait,
  input wire logic                      dpm_rail_is_on,
  input wire logic                      dpm_rail_off_cmd,
  input wire logic                      outcome_valid,
  input wire logic                      hard_reset_req,
  input wire swap_caps_pkg::pe_state_t  state
);
  logic armed_q;
  logic acc;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // replies count only after the request went out
  assign acc = rx_valid && rx_msg == MSG_ACCEPT;
  always_ff @(posedge clk) begin
    if (!rst_n || $changed(state)) armed_q <= 1'b0;
    else if (tx_req) armed_q <= 1'b1;
  end
  // ==========================================================
  // properties
  swap_send_a: assert property ($changed(state) && state == sink_role_swap_request_state
    |=> tx_req && tx_msg == MSG_PR_SWAP) else $error("swap request not sent");
  swap_accept_a: assert property (state == sink_role_swap_request_state && armed_q && acc
    |=> state == sink_power_off_transition_state) else $error("accept not followed");
  swap_back_a: assert property (state == sink_role_swap_request_state && armed_q && rx_valid
    && rx_msg inside {MSG_REJECT, MSG_WAIT} |=> state == sink_ready_state) else $error("swap not dropped");
  refuse_msg_a: assert property ($changed(state) && state == sink_role_swap_refusal_state
    |=> tx_req && tx_msg == (dpm_swap_wait ? MSG_WAIT : MSG_REJECT)) else $error("wrong refusal");
  refuse_done_a: assert property (state == sink_role_swap_refusal_state && tx_done
    |=> state == sink_ready_state) else $error("refusal stuck");
  query_out_a: assert property ($past(state) == source_side_cap_query_state && state == source_ready_state
    |-> ##[0:1] outcome_valid) else $error("no outcome");
  rail_gate_a: assert property (!dpm_is_dfp && state inside {source_ready_state, sink_ready_state}
    |=> state != rail_swap_request_state) else $error("rail swap not gated");
  rail_accept_a: assert property (state == rail_swap_request_state && armed_q && acc
    |=> state == ($past(dpm_rail_is_on) ? wait_partner_rail_state : rail_turn_on_state)) else $error("bad rail path");
  rail_ready_a: assert property (state == wait_partner_rail_state && rx_valid && rx_msg == MSG_PS_RDY
    |=> state == rail_turn_off_state) else $error("ready ignored");
  rail_off_a: assert property ($rose(state == rail_turn_off_state) |-> ##[0:1] dpm_rail_off_cmd)
    else $error("no off command");
  hard_role_a: assert property (state == wait_partner_rail_state ##1 state inside {source_hard_reset_state,
    sink_hard_reset_state} |-> state == (PROVIDER_ROLE ? source_hard_reset_state : sink_hard_reset_state))
    else $error("wrong hard reset");
  hard_flag_a: assert property ($rose(state == source_hard_reset_state) |-> ##[0:1] hard_reset_req)
    else $error("no hard reset flag");
endmodule
bind swap_caps_fsm swap_caps_chk #(.PROVIDER_ROLE(PROVIDER_ROLE)) i_swap_caps_chk (.clk, .rst_n, .rx_valid,
  .rx_msg, .tx_req, .tx_msg, .tx_done, .dpm_is_dfp, .dpm_swap_wait, .dpm_rail_is_on, .dpm_rail_off_cmd,
  .outcome_valid, .hard_reset_req, .state);
`default_nettype wire

/* dual_role_swap_and_caps_fsm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_role_swap_and_caps_fsm_tb
  import swap_caps_pkg::*;
;
  logic clk, rst_n, rx_valid, tx_req, tx_done, inj, dpm_is_source, dpm_is_dfp;
  logic dpm_get_src_cap_req, dpm_get_snk_cap_req, dpm_pr_swap_req, dpm_rail_swap_req;
  logic dpm_refuse_pending, dpm_swap_wait, dpm_rail_is_on, dpm_rail_on_cmd, dpm_rail_off_cmd;
  logic dpm_caps_fetch, outcome_valid, hard_reset_req, fetched;
  logic [1:0] outcome_code, last_out;
  logic [7:0] gap;
  msg_t rx_msg, tx_msg, reply, inj_msg, last_tx;
  pe_state_t state;
  int num_errors, total_checks;
  swap_caps_fsm #(.RAIL_CAPABLE(1'b1), .PROVIDER_ROLE(1'b1)) i_swap_caps_fsm (.clk, .rst_n, .rx_valid,
    .rx_msg, .tx_req, .tx_msg, .tx_done, .dpm_is_source, .dpm_is_dfp, .dpm_get_src_cap_req,
    .dpm_get_snk_cap_req, .dpm_pr_swap_req, .dpm_rail_swap_req, .dpm_refuse_pending, .dpm_swap_wait,
    .dpm_rail_is_on, .dpm_rail_on_cmd, .dpm_rail_off_cmd, .dpm_caps_fetch, .outcome_valid,
    .outcome_code, .hard_reset_req, .state);
  far_end_model i_far_end_model (.clk, .rst_n, .tx_req, .reply, .gap, .inj, .inj_msg, .rx_msg, .rx_valid,
    .tx_done);
  // ==========================================================
  // clock and monitors; pulses are latched so checks need not hit their cycle
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tx_req) last_tx <= tx_msg;
    if (outcome_valid) last_out <= outcome_code;
    if (dpm_caps_fetch) fetched <= 1'b1;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic go(input pe_state_t e, input int lim);
    pe_state_t s;
    int i;
    s = state;
    for (i = 0; i < lim && state === s; i++) @(negedge clk);
    chk("state", e, state);
  endtask
  task automatic send(input msg_t m);
    inj_msg = m;
    inj = 1'b1;
    @(negedge clk);
    inj = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_pr_swap;
    msg_t r [4] = '{MSG_ACCEPT, MSG_REJECT, MSG_WAIT, MSG_NONE};
    foreach (r[k]) begin
      reply = r[k];
      gap = 8'h02 + 8'(k * 5);
      dpm_pr_swap_req = 1'b1;
      @(negedge clk);
      dpm_pr_swap_req = 1'b0;
      chk("swap_enter", sink_role_swap_request_state, state);
      go((k == 0) ? sink_power_off_transition_state : sink_ready_state, 600);
      chk("swap_msg", MSG_PR_SWAP, last_tx);
      if (k == 0) begin
        dpm_is_source = 1'b1;
        go(source_ready_state, 5);
        dpm_is_source = 1'b0;
        go(sink_ready_state, 5);
      end
    end
  endtask
  task automatic t_refuse;
    reply = MSG_NONE;
    dpm_refuse_pending = 1'b1;
    for (int w = 0; w < 2; w++) begin
      dpm_swap_wait = w[0];
      send(MSG_PR_SWAP);
      go(sink_role_swap_refusal_state, 5);
      go(sink_ready_state, 10);
      chk("refuse_msg", w[0] ? MSG_WAIT : MSG_REJECT, last_tx);
    end
    dpm_refuse_pending = 1'b0;
  endtask
  task automatic t_src_caps;
    msg_t r [3] = '{MSG_SRC_CAPS, MSG_REJECT, MSG_NONE};
    logic [1:0] o [3] = '{OUT_CAPS, OUT_REJECT, OUT_TIMEOUT};
    dpm_is_source = 1'b1;
    go(source_ready_state, 5);
    foreach (r[k]) begin
      reply = r[k];
      last_out = 2'h0;
      dpm_get_src_cap_req = 1'b1;
      @(negedge clk);
      dpm_get_src_cap_req = 1'b0;
      chk("query_enter", source_side_cap_query_state, state);
      go(source_ready_state, 600);
      repeat (2) @(negedge clk);
      chk("query_msg", MSG_GET_SRC, last_tx);
      chk("query_out", {2'b00, o[k]}, {2'b00, last_out});
    end
    reply = MSG_NONE;
    fetched = 1'b0;
    send(MSG_GET_SNK);
    go(source_side_cap_reply_state, 5);
    go(source_ready_state, 10);
    chk("snk_caps", MSG_SNK_CAPS, last_tx);
    chk("fetch", 4'h1, {3'b000, fetched});
  endtask
  task automatic t_snk_caps;
    msg_t r [3] = '{MSG_SNK_CAPS, MSG_REJECT, MSG_NONE};
    logic [1:0] o [3] = '{OUT_CAPS, OUT_REJECT, OUT_TIMEOUT};
    dpm_is_source = 1'b0;
    go(sink_ready_state, 5);
    foreach (r[k]) begin
      reply = r[k];
      last_out = 2'h0;
      dpm_get_snk_cap_req = 1'b1;
      @(negedge clk);
      dpm_get_snk_cap_req = 1'b0;
      chk("snk_query", sink_side_cap_query_state, state);
      go(sink_ready_state, 600);
      repeat (2) @(negedge clk);
      chk("snk_query_msg", MSG_GET_SNK, last_tx);
      chk("snk_out", {2'b00, o[k]}, {2'b00, last_out});
    end
    // answer from a pending swap request; its timer must not fire later
    reply = MSG_NONE;
    dpm_pr_swap_req = 1'b1;
    @(negedge clk);
    dpm_pr_swap_req = 1'b0;
    repeat (3) @(negedge clk);
    fetched = 1'b0;
    send(MSG_GET_SRC);
    go(sink_side_cap_reply_state, 5);
    go(sink_ready_state, 10);
    chk("src_caps", MSG_SRC_CAPS, last_tx);
    chk("src_fetch", 4'h1, {3'b000, fetched});
    repeat (600) @(negedge clk);
    chk("late_expiry", sink_ready_state, state);
  endtask
  task automatic t_rail;
    dpm_rail_swap_req = 1'b1;
    repeat (3) @(negedge clk);
    chk("rail_gate", sink_ready_state, state);
    dpm_rail_swap_req = 1'b0;
    dpm_is_dfp = 1'b1;
    for (int k = 0; k < 4; k++) begin
      dpm_rail_is_on = (k != 1);
      reply = (k == 3) ? MSG_REJECT : MSG_ACCEPT;
      dpm_rail_swap_req = 1'b1;
      @(negedge clk);
      dpm_rail_swap_req = 1'b0;
      chk("rail_enter", rail_swap_request_state, state);
      go((k == 3) ? sink_ready_state : (k == 1) ? rail_turn_on_state : wait_partner_rail_state, 600);
      chk("rail_msg", MSG_RAIL_SWAP, last_tx);
      repeat (2) @(negedge clk);
      if (k == 0) begin
        send(MSG_PS_RDY);
        go(rail_turn_off_state, 5);
        repeat (2) @(negedge clk);
        chk("off_cmd", 4'h1, {3'b000, dpm_rail_off_cmd});
        dpm_rail_is_on = 1'b0;
        go(sink_ready_state, 5);
      end else if (k == 1) begin
        chk("on_cmd", 4'h1, {3'b000, dpm_rail_on_cmd});
        dpm_rail_is_on = 1'b1;
        go(rail_send_ready_state, 5);
        go(sink_ready_state, 10);
        chk("ready_msg", MSG_PS_RDY, last_tx);
      end else if (k == 2) begin
        go(source_hard_reset_state, 2100);
        chk("hard_req", 4'h1, {3'b000, hard_reset_req});
        repeat (6) @(negedge clk);
      end
    end
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {rst_n, inj, dpm_is_source, dpm_is_dfp, dpm_get_src_cap_req, dpm_get_snk_cap_req} = '0;
    {dpm_pr_swap_req, dpm_rail_swap_req, dpm_refuse_pending, dpm_swap_wait, dpm_rail_is_on} = '0;
    {num_errors, total_checks, fetched, last_out} = '0;
    reply = MSG_NONE;
    inj_msg = MSG_NONE;
    last_tx = MSG_NONE;
    gap = 8'h04;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_pr_swap();
    t_refuse();
    t_src_caps();
    t_snk_caps();
    t_rail();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
